// ===== rtl/sdms_pkg.sv
// Constants for the converter mode sequencer: register map, field layout,
// mode codes, reset values and calibration lengths.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
package sdms_pkg;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_MODE     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_PRI_REF  = 8'h08;
   localparam logic [7:0] OFS_AUX_CFG  = 8'h0C;
   localparam logic [7:0] OFS_AUX_A    = 8'h10;
   localparam logic [7:0] OFS_AUX_B    = 8'h14;
   localparam logic [7:0] OFS_FILTER   = 8'h18;
   localparam logic [7:0] OFS_POWER    = 8'h1C;
   localparam logic [7:0] OFS_PRI_DATA = 8'h20;
   localparam logic [7:0] OFS_AUX_DATA = 8'h24;
   localparam logic [7:0] OFS_PRI_OFS  = 8'h28;
   localparam logic [7:0] OFS_PRI_GAIN = 8'h2C;
   localparam logic [7:0] OFS_AUX_OFS  = 8'h30;
   localparam logic [7:0] OFS_AUX_GAIN = 8'h34;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MODE_LSB     = 0;
   localparam int CHOP_OFF_BIT = 3;
   localparam int AUX_EN_BIT   = 4;
   localparam int PRI_EN_BIT   = 5;
   localparam int ST_PRI_RDY   = 7;
   localparam int ST_AUX_RDY   = 6;
   localparam int ST_PRI_CAL   = 5;
   localparam int ST_AUX_CAL   = 4;
   localparam int ST_AUX_ERR   = 0;
   localparam int REF_LSB      = 6;
   localparam int AUX_REF_BIT  = 6;
   localparam int CHAN_LSB     = 0;
   localparam int PD_BIT       = 0;

   // ****************************************************************
   // Mode codes, input selections and reset values
   // ****************************************************************
   localparam logic [2:0] MD_OFF    = 3'h0;
   localparam logic [2:0] MD_IDLE   = 3'h1;
   localparam logic [2:0] MD_SINGLE = 3'h2;
   localparam logic [2:0] MD_CONT   = 3'h3;
   localparam logic [2:0] MD_IZS    = 3'h4;
   localparam logic [2:0] MD_IFS    = 3'h5;
   localparam logic [2:0] MD_SZS    = 3'h6;
   localparam logic [2:0] MD_SFS    = 3'h7;
   localparam logic [1:0] IN_PINS   = 2'h0;
   localparam logic [1:0] IN_SHORT  = 2'h1;
   localparam logic [1:0] IN_REF    = 2'h2;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [23:0] RST_WORD = 24'h000000;

   // ****************************************************************
   // Calibration length in converter output periods
   // ****************************************************************
   localparam logic [2:0] CAL_PER_CHOP   = 3'h2;
   localparam logic [2:0] CAL_PER_NOCHOP = 3'h4;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      SQ_STOP = 4'b0001,
      SQ_IDLE = 4'b0010,
      SQ_CONV = 4'b0100,
      SQ_CAL  = 4'b1000
   } sdms_seq_e;

endpackage : sdms_pkg

// ===== rtl/sdms_out_counter.sv
// Counter of converter output periods, used to time calibrations.
// Assumes inc is a one-cycle pulse per accepted filter output.
module sdms_out_counter #(
   parameter int W = 3
) (
   input  wire logic         clk_sys, // System clock.
   input  wire logic         rst,     // Asynchronous reset, active high.
   input  wire logic         clr,     // Restart the count.
   input  wire logic         inc,     // One output period elapsed.
   output logic [W-1:0]      cnt      // Periods counted so far.
);

   // ****************************************************************
   // Count
   // ****************************************************************
   // Clear wins over a count so a converter reset always starts at zero.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (clr) begin
         cnt <= '0;
      end else if (inc) begin
         cnt <= cnt + W'(1);
      end
   end

endmodule : sdms_out_counter

// ===== rtl/sdms_top.sv
// Mode and sequencing control for a primary and an auxiliary sigma-delta
// converter, with an APB register file.
// Assumes the decimation filters deliver one-cycle result pulses with data,
// synchronous to clk_sys, and honour the filter reset outputs.
//
// The register addresses and register access over APB were chosen for this implementation.
module sdms_top #(
   parameter logic [3:0] TEMP_CHAN = 4'hF // Aux channel code of the temperature sensor.
) (
   input  wire logic        clk_sys,      // System clock, 125 MHz.
   input  wire logic        rst,          // Asynchronous reset, active high.
   input  wire logic        psel,         // APB select.
   input  wire logic        penable,      // APB access phase.
   input  wire logic        pwrite,       // APB write.
   input  wire logic [7:0]  paddr,        // APB byte address.
   input  wire logic [31:0] pwdata,       // APB write data.
   output logic      [31:0] prdata,       // APB read data.
   output logic             pready,       // APB ready.
   output logic             pslverr,      // APB error on unmapped address.
   input  wire logic        pri_out_valid, // Primary filter result pulse.
   input  wire logic [23:0] pri_out_data, // Primary filter result.
   input  wire logic        aux_out_valid, // Aux filter result pulse.
   input  wire logic [23:0] aux_out_data, // Aux filter result.
   output logic             pri_filt_rst, // Hold primary filter and modulator in reset.
   output logic             aux_filt_rst, // Hold aux filter and modulator in reset.
   output logic             mod_clk_en,   // Modulator clocks running.
   output logic             chop_en,      // Chopping on for both converters.
   output logic      [1:0]  pri_in_sel,   // Primary input: pins, short or reference.
   output logic      [1:0]  aux_in_sel,   // Aux input: pins, short or reference.
   output logic      [1:0]  ref_select_bits, // Primary reference choice.
   output logic             aux_ref_select_bit, // Aux reference choice.
   output logic      [3:0]  primary_channel_bits, // Primary channel.
   output logic      [3:0]  aux_channel_bits, // Aux channel.
   output logic      [7:0]  filter_decimation_word // Filter decimation setting.
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic [2:0]        conv_mode_field;
      logic              chop_off;
      logic              aux_conv_enable;
      logic              primary_conv_enable;
      logic              cpu_powerdown_bit;
      logic [7:0]        primary_channel_ref_reg;
      logic [7:0]        aux_config_reg;
      logic [7:0]        aux_control_reg_a;
      logic [7:0]        aux_control_reg_b;
      logic [7:0]        sf;
      logic [23:0]       pri_data;
      logic [23:0]       aux_data;
      logic [23:0]       pri_ofs;
      logic [23:0]       pri_gain;
      logic [23:0]       aux_ofs;
      logic [23:0]       aux_gain;
      logic              pri_rdy;
      logic              aux_ready_flag;
      logic              pri_cal;
      logic              aux_cal;
      logic              aux_error_flag;
      logic              pri_done;
      logic              aux_done;
      logic              aux_wait;
      logic              pri_frst;
      logic              aux_frst;
      logic              mclk;
      logic              chop;
      logic [1:0]        pri_in;
      logic [1:0]        aux_in;
      sdms_pkg::sdms_seq_e seq;
   } sdms_state_s;

   sdms_state_s s;
   sdms_state_s next_s;
   logic        rst_both;
   logic        rst_aux;
   logic        pri_ok;
   logic        aux_ok;
   logic        pri_clr;
   logic        aux_clr;
   logic [2:0]  pri_cnt;
   logic [2:0]  aux_cnt;

   // ****************************************************************
   // Calibration period counters
   // ****************************************************************
   sdms_out_counter #(.W(3)) u_pri_cnt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clr     (pri_clr),
      .inc     (pri_ok),
      .cnt     (pri_cnt)
   );

   sdms_out_counter #(.W(3)) u_aux_cnt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clr     (aux_clr),
      .inc     (aux_ok),
      .cnt     (aux_cnt)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   // One process holds the bus, the resets and the sequencing so that the
   // priority between a software write and a completion is explicit.
   always_comb begin
      logic       acc;
      logic       wr;
      logic       hold;
      logic [2:0] md;
      logic [2:0] last;
      logic       pri_last;
      logic       aux_last;
      logic       pri_fin;
      logic       aux_fin;
      acc      = 1'b0;
      wr       = 1'b0;
      hold     = 1'b0;
      md       = 3'h0;
      last     = 3'h0;
      pri_last = 1'b0;
      aux_last = 1'b0;
      pri_fin  = 1'b0;
      aux_fin  = 1'b0;
      next_s   = s;
      rst_both = 1'b0;
      rst_aux  = 1'b0;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      acc = psel & penable & s.pready;
      wr  = acc & pwrite;

      // One wait state: read data and error are loaded with pready.
      if (psel && penable && !s.pready) begin
         next_s.pready  = 1'b1;
         next_s.prdata  = 32'h00000000;
         case (paddr)
            sdms_pkg::OFS_MODE: begin
               next_s.prdata[sdms_pkg::MODE_LSB +: 3] = s.conv_mode_field;
               next_s.prdata[sdms_pkg::CHOP_OFF_BIT]  = s.chop_off;
               next_s.prdata[sdms_pkg::AUX_EN_BIT]    = s.aux_conv_enable;
               next_s.prdata[sdms_pkg::PRI_EN_BIT]    = s.primary_conv_enable;
            end
            sdms_pkg::OFS_STATUS: begin
               next_s.prdata[sdms_pkg::ST_PRI_RDY] = s.pri_rdy;
               next_s.prdata[sdms_pkg::ST_AUX_RDY] = s.aux_ready_flag;
               next_s.prdata[sdms_pkg::ST_PRI_CAL] = s.pri_cal;
               next_s.prdata[sdms_pkg::ST_AUX_CAL] = s.aux_cal;
               next_s.prdata[sdms_pkg::ST_AUX_ERR] = s.aux_error_flag;
            end
            sdms_pkg::OFS_PRI_REF:  next_s.prdata[7:0] = s.primary_channel_ref_reg;
            sdms_pkg::OFS_AUX_CFG:  next_s.prdata[7:0] = s.aux_config_reg;
            sdms_pkg::OFS_AUX_A:    next_s.prdata[7:0] = s.aux_control_reg_a;
            sdms_pkg::OFS_AUX_B:    next_s.prdata[7:0] = s.aux_control_reg_b;
            sdms_pkg::OFS_FILTER:   next_s.prdata[7:0] = s.sf;
            sdms_pkg::OFS_POWER:    next_s.prdata[sdms_pkg::PD_BIT] = s.cpu_powerdown_bit;
            sdms_pkg::OFS_PRI_DATA: next_s.prdata[23:0] = s.pri_data;
            sdms_pkg::OFS_AUX_DATA: next_s.prdata[23:0] = s.aux_data;
            sdms_pkg::OFS_PRI_OFS:  next_s.prdata[23:0] = s.pri_ofs;
            sdms_pkg::OFS_PRI_GAIN: next_s.prdata[23:0] = s.pri_gain;
            sdms_pkg::OFS_AUX_OFS:  next_s.prdata[23:0] = s.aux_ofs;
            sdms_pkg::OFS_AUX_GAIN: next_s.prdata[23:0] = s.aux_gain;
            default:                next_s.pslverr = 1'b1;
         endcase
      end

      // Accepted filter results; anything produced under reset is dropped.
      pri_ok = pri_out_valid & ~s.pri_frst & ~s.cpu_powerdown_bit;
      aux_ok = aux_out_valid & ~s.aux_frst & ~s.cpu_powerdown_bit & ~s.aux_wait;

      // Completion handling per sequencer state.
      last     = s.chop_off ? sdms_pkg::CAL_PER_NOCHOP : sdms_pkg::CAL_PER_CHOP;
      pri_last = pri_ok && (pri_cnt == last - 3'h1);
      aux_last = aux_ok && (aux_cnt == last - 3'h1);
      case (s.seq)
         sdms_pkg::SQ_CONV: begin
            if (pri_ok && !s.pri_done) begin
               next_s.pri_data = pri_out_data;
               next_s.pri_rdy  = 1'b1;
               next_s.pri_done = (s.conv_mode_field == sdms_pkg::MD_SINGLE);
            end
            if (aux_ok && !s.aux_done) begin
               next_s.aux_data       = aux_out_data;
               next_s.aux_ready_flag = 1'b1;
               next_s.aux_done       = (s.conv_mode_field == sdms_pkg::MD_SINGLE);
            end
         end
         sdms_pkg::SQ_CAL: begin
            md = s.conv_mode_field;
            if (pri_last && !s.pri_done) begin
               if (md[0]) begin
                  next_s.pri_gain = pri_out_data;
               end else begin
                  next_s.pri_ofs = pri_out_data;
               end
               next_s.pri_rdy  = 1'b1;
               next_s.pri_cal  = 1'b1;
               next_s.pri_done = 1'b1;
            end
            if (aux_last && !s.aux_done) begin
               // The temperature sensor cannot be calibrated; flag it instead.
               if (s.aux_config_reg[sdms_pkg::CHAN_LSB +: 4] == TEMP_CHAN) begin
                  next_s.aux_error_flag = 1'b1;
               end else begin
                  next_s.aux_cal = 1'b1;
                  if (md[0]) begin
                     next_s.aux_gain = aux_out_data;
                  end else begin
                     next_s.aux_ofs = aux_out_data;
                  end
               end
               next_s.aux_ready_flag = 1'b1;
               next_s.aux_done       = 1'b1;
            end
         end
         sdms_pkg::SQ_STOP, sdms_pkg::SQ_IDLE: begin
         end
         default: begin
         end
      endcase

      // Single conversion and calibration end in MD_OFF once every
      // enabled converter has finished.
      pri_fin = next_s.pri_done | ~s.primary_conv_enable;
      aux_fin = next_s.aux_done | ~s.aux_conv_enable;
      if ((s.conv_mode_field == sdms_pkg::MD_SINGLE || s.seq == sdms_pkg::SQ_CAL) &&
          pri_fin && aux_fin && (s.primary_conv_enable || s.aux_conv_enable)) begin
         next_s.conv_mode_field = sdms_pkg::MD_OFF;
      end

      // Register writes; a write in the same cycle as a completion wins.
      if (wr) begin
         case (paddr)
            sdms_pkg::OFS_MODE: begin
               next_s.conv_mode_field     = pwdata[sdms_pkg::MODE_LSB +: 3];
               next_s.chop_off            = pwdata[sdms_pkg::CHOP_OFF_BIT];
               next_s.aux_conv_enable     = pwdata[sdms_pkg::AUX_EN_BIT];
               next_s.primary_conv_enable = pwdata[sdms_pkg::PRI_EN_BIT];
               rst_both = 1'b1;
               if (pwdata[sdms_pkg::MODE_LSB + 2]) begin
                  next_s.pri_rdy        = 1'b0;
                  next_s.aux_ready_flag = 1'b0;
                  next_s.pri_cal        = 1'b0;
                  next_s.aux_cal        = 1'b0;
                  next_s.aux_error_flag = 1'b0;
               end
            end
            sdms_pkg::OFS_AUX_A: begin
               next_s.aux_control_reg_a = pwdata[7:0];
               rst_both = s.primary_conv_enable;
               rst_aux  = 1'b1;
            end
            sdms_pkg::OFS_AUX_B: begin
               next_s.aux_control_reg_b = pwdata[7:0];
               rst_both = s.primary_conv_enable;
               rst_aux  = 1'b1;
            end
            sdms_pkg::OFS_AUX_CFG: begin
               next_s.aux_config_reg = pwdata[7:0];
               rst_aux = 1'b1;
            end
            sdms_pkg::OFS_PRI_REF: next_s.primary_channel_ref_reg = pwdata[7:0];
            sdms_pkg::OFS_FILTER:  next_s.sf = pwdata[7:0];
            sdms_pkg::OFS_POWER: begin
               next_s.cpu_powerdown_bit = pwdata[sdms_pkg::PD_BIT];
               rst_both = s.cpu_powerdown_bit & ~pwdata[sdms_pkg::PD_BIT];
            end
            default: begin
            end
         endcase
      end

      // Converter resets and the aux alignment to the primary output cycle.
      if (rst_both) begin
         next_s.pri_done = 1'b0;
         next_s.aux_done = 1'b0;
         next_s.aux_wait = 1'b0;
      end else if (rst_aux) begin
         next_s.aux_done = 1'b0;
         // With the primary still producing, wait for its next output.
         next_s.aux_wait = (s.seq == sdms_pkg::SQ_CONV || s.seq == sdms_pkg::SQ_CAL) &&
                           s.primary_conv_enable && !s.pri_done;
      end else if (pri_ok || s.pri_frst) begin
         next_s.aux_wait = 1'b0;
      end

      // Sequencer state follows the mode field; power-down holds both converters
      // in reset and stops the modulator clocks but leaves the field untouched for the restart.
      case (next_s.conv_mode_field)
         sdms_pkg::MD_OFF:                    next_s.seq = sdms_pkg::SQ_STOP;
         sdms_pkg::MD_IDLE:                   next_s.seq = sdms_pkg::SQ_IDLE;
         sdms_pkg::MD_SINGLE, sdms_pkg::MD_CONT: next_s.seq = sdms_pkg::SQ_CONV;
         default:                             next_s.seq = sdms_pkg::SQ_CAL;
      endcase
      hold = next_s.cpu_powerdown_bit | (next_s.seq == sdms_pkg::SQ_STOP) |
             (next_s.seq == sdms_pkg::SQ_IDLE);
      next_s.pri_frst = hold | rst_both | ~next_s.primary_conv_enable |
                        next_s.pri_done;
      next_s.aux_frst = hold | rst_both | rst_aux | ~next_s.aux_conv_enable |
                        next_s.aux_done | next_s.aux_wait;
      next_s.mclk = ~next_s.cpu_powerdown_bit &
                    (next_s.conv_mode_field != sdms_pkg::MD_OFF);
      next_s.chop = ~next_s.chop_off;

      // Input routing during calibrations; system ones keep the pins.
      case (next_s.conv_mode_field)
         sdms_pkg::MD_IZS: next_s.pri_in = sdms_pkg::IN_SHORT;
         sdms_pkg::MD_IFS: next_s.pri_in = sdms_pkg::IN_REF;
         default:          next_s.pri_in = sdms_pkg::IN_PINS;
      endcase
      next_s.aux_in = next_s.pri_in;
   end

   // Period counters restart on any converter reset or outside calibration.
   assign pri_clr = rst_both | (s.seq != sdms_pkg::SQ_CAL) | s.pri_frst;
   assign aux_clr = rst_both | rst_aux | (s.seq != sdms_pkg::SQ_CAL) | s.aux_frst;

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s                         <= '0;
         s.conv_mode_field         <= sdms_pkg::MD_OFF;
         s.primary_channel_ref_reg <= sdms_pkg::RST_BYTE;
         s.aux_config_reg          <= sdms_pkg::RST_BYTE;
         s.pri_data                <= sdms_pkg::RST_WORD;
         s.aux_data                <= sdms_pkg::RST_WORD;
         s.pri_frst                <= 1'b1;
         s.aux_frst                <= 1'b1;
         s.chop                    <= 1'b1;
         s.seq                     <= sdms_pkg::SQ_STOP;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every output is a bit of the state register.
   assign prdata                 = s.prdata;
   assign pready                 = s.pready;
   assign pslverr                = s.pslverr;
   assign pri_filt_rst           = s.pri_frst;
   assign aux_filt_rst           = s.aux_frst;
   assign mod_clk_en             = s.mclk;
   assign chop_en                = s.chop;
   assign pri_in_sel             = s.pri_in;
   assign aux_in_sel             = s.aux_in;
   assign ref_select_bits        = s.primary_channel_ref_reg[sdms_pkg::REF_LSB +: 2];
   assign aux_ref_select_bit     = s.aux_config_reg[sdms_pkg::AUX_REF_BIT];
   assign primary_channel_bits   = s.primary_channel_ref_reg[sdms_pkg::CHAN_LSB +: 4];
   assign aux_channel_bits       = s.aux_config_reg[sdms_pkg::CHAN_LSB +: 4];
   assign filter_decimation_word = s.sf;

endmodule : sdms_top

// ===== sim/sdms_chk.sv
// Checker of the mode sequencer: bus answer, converter resets and input choice.
// Assumes it is bound to sdms_top and sees only that module's ports.
module sdms_chk (
   input wire logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, // Bus.
   input wire logic [7:0]  paddr,                       // Byte address.
   input wire logic [31:0] pwdata, prdata,              // Bus data.
   input wire logic        pri_filt_rst, aux_filt_rst, mod_clk_en, chop_en, // Converters.
   input wire logic        pri_out_valid,               // Primary result pulse.
   input wire logic [1:0]  pri_in_sel                   // Primary input choice.
);
   // *****
   // Helpers
   // *****
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire  wr      = psel && penable && pready && pwrite;
   wire  wr_mode = wr && paddr == 8'h00;
   logic chop_exp;
   // Expected chop state; the mirror lags the write, so it is compared once settled.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) chop_exp <= 1'b1;
      else if (wr_mode) chop_exp <= !pwdata[3];
   end
   a_ready_one: assert property (pready |=> !pready) else $error("ready held too long");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   a_mode_reset: assert property (wr_mode |=> pri_filt_rst && aux_filt_rst)
      else $error("mode write left a converter running");
   a_aux_only: assert property (wr && paddr == 8'h0C |=> aux_filt_rst && !$rose(pri_filt_rst))
      else $error("aux write disturbed primary");
   a_idle_clocks: assert property (wr_mode && pwdata[2:0] == 3'h1 |=> ##1 mod_clk_en && pri_filt_rst)
      else $error("idle state wrong");
   a_short_in: assert property (wr_mode && pwdata[5] && pwdata[2:0] == 3'h4 |-> ##[1:2] pri_in_sel == 2'h1)
      else $error("short not connected");
   a_ref_in: assert property (wr_mode && pwdata[5] && pwdata[2:0] == 3'h5 |-> ##[1:2] pri_in_sel == 2'h2)
      else $error("reference not connected");
   a_chop_mirror: assert property (!wr_mode && !$past(wr_mode) |-> chop_en == chop_exp)
      else $error("chop state wrong");
   a_bad_addr: assert property (psel && penable && pready && paddr > 8'h34 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   c_cal: cover property (wr_mode && pwdata[2]);
   c_result: cover property (pri_out_valid && !pri_filt_rst);
   c_refused: cover property (pslverr);
endmodule : sdms_chk
bind sdms_top sdms_chk chk_u (.*);

// ===== sim/sdms_top_tb.sv
// Self-checking bench of the mode sequencer: registers, single run and calibrations.
// Assumes the bench stands in for the filters by driving result pulses itself.
module sdms_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pri_out_valid = 0;
   logic [7:0]  paddr = 8'h00, filter_decimation_word;
   logic [31:0] pwdata = 32'h0, prdata, rd, want, seed = 32'hC045;
   logic [23:0] pri_out_data = 24'h0, dat;
   logic        aux_out_valid = 0;
   logic [23:0] aux_out_data = 24'h0;
   logic        pready, pslverr, pri_filt_rst, aux_filt_rst, mod_clk_en, chop_en;
   logic [1:0]  pri_in_sel;
   int          err_total = 0, checks_done = 0, n;
   always #4 clk_sys = ~clk_sys;
   sdms_top dut_u (.*, .aux_in_sel(),
      .ref_select_bits(), .aux_ref_select_bit(), .primary_channel_bits(), .aux_channel_bits());
   // *****
   // Tasks
   // *****
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
      checks_done++;
      if (got !== exp_v) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp_v);
      end
   endtask : chk
   // Ready and read data are taken at the rising edge that completes the access.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 20);
      rd = prdata;
      chk(pready, 1'b1);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk
   // A result is offered once either filter leaves reset, or anyway after a bounded wait.
   task automatic pulse();
      n = 0;
      do @(negedge clk_sys); while ((pri_filt_rst && aux_filt_rst) !== 1'b0 && n++ < 20);
      seed = lfsr(seed);
      dat = seed[23:0];
      @(posedge clk_sys);
      {pri_out_valid, aux_out_valid, pri_out_data, aux_out_data} <= {2'b11, dat, dat};
      @(posedge clk_sys);
      {pri_out_valid, aux_out_valid} <= 2'b00;
   endtask : pulse
   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      chk({pri_filt_rst, mod_clk_en}, 2'b10);
      rst <= 1'b0;
      rdchk(8'h00, 32'h0);
      rdchk(8'h40, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         apb(1'b1, 8'h18, seed);
         rdchk(8'h18, {24'h0, seed[7:0]});
         chk(filter_decimation_word, seed[7:0]);
      end
      apb(1'b1, 8'h0C, 32'h3);
      apb(1'b1, 8'h00, 32'h21);
      repeat (3) @(negedge clk_sys);
      chk({mod_clk_en, pri_filt_rst}, 2'b11);
      apb(1'b1, 8'h00, 32'h22);
      rdchk(8'h00, 32'h22);
      pulse();
      want = {8'h0, dat};
      rdchk(8'h20, want);
      rdchk(8'h04, 32'h80);
      rdchk(8'h00, 32'h20);
      pulse();
      rdchk(8'h20, want);
      apb(1'b1, 8'h18, 32'hFF);
      for (int m = 4; m < 8; m++) begin
         want = 32'h20 | {m[0], 3'h0};
         apb(1'b1, 8'h00, want | m);
         rdchk(8'h04, 32'h0);
         chk(chop_en, !m[0]);
         repeat (m[0] ? 3 : 1) pulse();
         rdchk(8'h00, want | m);
         pulse();
         rdchk(m[0] ? 8'h2C : 8'h28, {8'h0, dat});
         rdchk(8'h04, 32'hA0);
         rdchk(8'h00, want);
      end
      // Aux calibration on the temperature channel fails with ready and error set.
      apb(1'b1, 8'h0C, 32'h0F);
      apb(1'b1, 8'h00, 32'h14);
      repeat (2) pulse();
      rdchk(8'h04, 32'h41);
      rdchk(8'h30, 32'h0);
      rdchk(8'h00, 32'h10);
      end_of_test();
   end
endmodule : sdms_top_tb
